// file: hdl/sli_indicator.sv
/*
 * Status indicator driver for six pins shared with general-purpose I/O.
 * Assumes status inputs are asynchronous to clock; straps settle before reset release.
 */
// Overview of operation
// - Select bit set makes pin an indicator; GPIO input buffer and pull-up off.
// - Select bits, function code and polarity reset from straps.
// - Global off: open-drain pins undriven, push-pull pins held inactive.
// - Code 0: speed, duplex, link/act; code 1: 10-link/act, duplex, 100-link/act.
// - Code 2: speed, link/act, port 0 RX/TX; code 3: speed, link, activity.
// - Code 4: duplex, link, activity; code 5: 100-link, 10-link, activity.
// - Code 6 reserved; code 7 shows raw TX_EN and RX_DV per port.
// - Codes 0-5 active level is inverse of hard strap latched at reset.
// - Codes 0-5 inactive state leaves the pin undriven.
// - TX pulses active 80 ms then 80 ms inactive, ignoring link.
// - RX pulses active 80 ms then 80 ms inactive, ignoring link.
// - Activity pulses active 80 ms on traffic; held inactive without internal link.
// - Link is steadily active while link valid at either speed.
// - Link/activity active with link, pulses inactive 80 ms on traffic.
// - 100-link active only with valid 100 Mbps link.
// - 100-link/activity like link/activity but only at 100 Mbps.
// - 10-link active only with valid 10 Mbps link.
// - 10-link/activity like link/activity but only at 10 Mbps.
// - Duplex/collision active in full duplex with link, 80 ms pulses on collision in half with link.
// - Speed active at 100 Mbps, inactive at 10 Mbps or without link.
// - Code 7 uses push-pull drivers, all other codes open-drain/open-source.
// - Code 7 drives pin equal to its status signal without stretching.
`timescale 1ns/1ps
module sli_indicator (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Straps, sampled after reset release
	input wire logic [5:0] indicator_select_strap,
	input wire logic [2:0] indicator_function_strap,
	input wire logic [5:0] indicator_polarity_strap,
	// Configuration
	input wire logic cfg_write,
	input wire logic [5:0] indicator_select_bits,
	input wire logic [2:0] indicator_function_code,
	input wire logic indicator_global_off,
	// Port status, index is port number
	input wire logic [2:0] port_link,
	input wire logic [2:0] port_speed_100,
	input wire logic [2:0] port_full_duplex,
	input wire logic [2:0] port_collision,
	input wire logic [2:0] port_tx_en,
	input wire logic [2:0] port_rx_dv,
	input wire logic port0_external,
	// Pins
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe_b,
	output logic [5:0] gpio_input_enable,
	output logic [5:0] gpio_pullup_enable,
	// Configuration readback
	output logic [5:0] select_state,
	output logic [2:0] function_state
);
	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_sync_b;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_sync_r[1];

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic loaded;
		logic [5:0] sel;
		logic [2:0] fun;
		logic [5:0] strap_hi;
		logic off;
		logic [2:0] link_s1;
		logic [2:0] link_s2;
		logic [2:0] spd_s1;
		logic [2:0] spd_s2;
		logic [2:0] fdx_s1;
		logic [2:0] fdx_s2;
		logic [2:0] col_s1;
		logic [2:0] col_s2;
		logic [2:0] tx_s1;
		logic [2:0] tx_s2;
		logic [2:0] rx_s1;
		logic [2:0] rx_s2;
		logic ext_s1;
		logic ext_s2;
		logic [5:0] pout;
		logic [5:0] poe_b;
		logic [5:0] gin;
		logic [5:0] gpu;
	} sli_state_t;

	sli_state_t s_r;
	sli_state_t s_nxt;

	sli_stretch_if sif ();

	sli_stretch u_stretch (
		.clock(clock),
		.rst_sync_b(rst_sync_b),
		.sif(sif.stretch)
	);

	// ---------------------------------------------------------------
	// Decode and drive
	// ---------------------------------------------------------------
	logic [5:0] act;
	logic [5:0] evt;
	logic [5:0] active;
	logic push_pull;
	int i;

	// ---------------------------------------------------------------
	// Per-port indications
	// ---------------------------------------------------------------
	logic [2:0] traffic;
	logic [2:0] int_link;
	logic [2:0] spd_on;
	logic [2:0] l10_on;
	logic [2:0] col_evt;
	logic [2:0] lact_evt;
	logic [2:0] l100_evt;
	logic [2:0] l10_evt;
	logic [2:0] act_evt;
	genvar gp;

	// One set per port; port 0 only feeds the RX/TX and raw roles
	generate
		for (gp = 0; gp < sli_pkg::PORT_COUNT; gp++) begin : g_port
			assign traffic[gp] = s_r.tx_s2[gp] | s_r.rx_s2[gp];
			if (gp == 0) begin : g_ext
				// External port 0 ignores link for activity
				assign int_link[gp] = s_r.link_s2[gp] | s_r.ext_s2;
			end else begin : g_int
				// Internal PHYs need link for activity
				assign int_link[gp] = s_r.link_s2[gp];
			end
			// Steady roles, all gated by link
			assign spd_on[gp] = s_r.link_s2[gp] & s_r.spd_s2[gp];
			assign l10_on[gp] = s_r.link_s2[gp] & ~s_r.spd_s2[gp];
			// Traffic events; the stretchers drop them while busy
			assign col_evt[gp] = s_r.link_s2[gp] & ~s_r.fdx_s2[gp] & s_r.col_s2[gp];
			assign lact_evt[gp] = s_r.link_s2[gp] & traffic[gp];
			assign l100_evt[gp] = spd_on[gp] & traffic[gp];
			assign l10_evt[gp] = l10_on[gp] & traffic[gp];
			assign act_evt[gp] = int_link[gp] & traffic[gp];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Per-pin role decode
	// ---------------------------------------------------------------
	genvar gk;

	generate
		for (gk = 0; gk < sli_pkg::PIN_COUNT; gk++) begin : g_role
			// Pins 0-2 serve port 1, pins 3-5 port 2
			localparam int PRT = (gk < 3) ? 1 : 2;
			localparam int ROW = gk % 3;
			// Raw code: middle row is TX, top row is port 0 with TX on pin 5, rest RX
			localparam int RAW_PRT = (ROW == 2) ? 0 : PRT;
			localparam bit RAW_TX = (ROW == 1) || (gk == 5);
			logic pulse;
			logic pin_act;
			logic pin_evt;

			// Stretcher output for this pin, shared by every role
			assign pulse = sif.pulse_on[gk];

			// Roles change with the code; a running timer carries over
			always_comb begin
				pin_act = 1'b0;
				pin_evt = 1'b0;
				unique case (s_r.fun)
					// Speed, duplex, link/activity
					sli_pkg::FUN_SPD_DPX_LACT: begin
						if (ROW == 0) begin
							pin_act = spd_on[PRT];
						end else if (ROW == 1) begin
							// Full duplex steady, collisions stretched
							pin_act = s_r.link_s2[PRT] & (s_r.fdx_s2[PRT] | pulse);
							pin_evt = col_evt[PRT];
						end else begin
							// Idles active, blinks off on traffic
							pin_act = s_r.link_s2[PRT] & ~pulse;
							pin_evt = lact_evt[PRT];
						end
					end
					// 10-link/activity, duplex, 100-link/activity
					sli_pkg::FUN_10LA_DPX_100LA: begin
						if (ROW == 0) begin
							pin_act = l10_on[PRT] & ~pulse;
							pin_evt = l10_evt[PRT];
						end else if (ROW == 1) begin
							// Full duplex steady, collisions stretched
							pin_act = s_r.link_s2[PRT] & (s_r.fdx_s2[PRT] | pulse);
							pin_evt = col_evt[PRT];
						end else begin
							pin_act = spd_on[PRT] & ~pulse;
							pin_evt = l100_evt[PRT];
						end
					end
					// Speed, link/activity, port 0 RX and TX
					sli_pkg::FUN_SPD_LACT_RXTX: begin
						// Port 0 RX on the lower pin, TX on the upper
						if (gk == 2) begin
							pin_act = pulse;
							pin_evt = s_r.rx_s2[0];
						end else if (gk == 5) begin
							pin_act = pulse;
							pin_evt = s_r.tx_s2[0];
						end else if (ROW == 0) begin
							pin_act = spd_on[PRT];
						end else begin
							pin_act = s_r.link_s2[PRT] & ~pulse;
							pin_evt = lact_evt[PRT];
						end
					end
					// Activity on the top row; steady roles below, except code 4 duplex which stretches collisions
					sli_pkg::FUN_SPD_LINK_ACT,
					sli_pkg::FUN_DPX_LINK_ACT,
					sli_pkg::FUN_100L_10L_ACT: begin
						if (ROW == 2) begin
							// Idles inactive
							pin_act = int_link[PRT] & pulse;
							pin_evt = act_evt[PRT];
						end else if (s_r.fun == sli_pkg::FUN_100L_10L_ACT && ROW == 0) begin
							pin_act = spd_on[PRT];
						end else if (s_r.fun == sli_pkg::FUN_100L_10L_ACT) begin
							pin_act = l10_on[PRT];
						end else if (ROW == 1) begin
							pin_act = s_r.link_s2[PRT];
						end else if (s_r.fun == sli_pkg::FUN_SPD_LINK_ACT) begin
							pin_act = spd_on[PRT];
						end else begin
							pin_act = s_r.link_s2[PRT] & (s_r.fdx_s2[PRT] | pulse);
							pin_evt = col_evt[PRT];
						end
					end
					sli_pkg::FUN_RAW: begin
						// Level follows status with no stretch
						pin_act = RAW_TX ? s_r.tx_s2[RAW_PRT] : s_r.rx_s2[RAW_PRT];
					end
					default: begin
						// Reserved code shows nothing
						pin_act = 1'b0;
					end
				endcase
			end

			assign act[gk] = pin_act;
			assign evt[gk] = pin_evt;
		end
	endgenerate

	always_comb begin
		s_nxt = s_r;
		active = '0;
		// Synchronisers, second stage is the only reader of the first
		s_nxt.link_s1 = port_link;
		s_nxt.link_s2 = s_r.link_s1;
		s_nxt.spd_s1 = port_speed_100;
		s_nxt.spd_s2 = s_r.spd_s1;
		s_nxt.fdx_s1 = port_full_duplex;
		s_nxt.fdx_s2 = s_r.fdx_s1;
		s_nxt.col_s1 = port_collision;
		s_nxt.col_s2 = s_r.col_s1;
		s_nxt.tx_s1 = port_tx_en;
		s_nxt.tx_s2 = s_r.tx_s1;
		s_nxt.rx_s1 = port_rx_dv;
		s_nxt.rx_s2 = s_r.rx_s1;
		s_nxt.ext_s1 = port0_external;
		s_nxt.ext_s2 = s_r.ext_s1;
		s_nxt.off = indicator_global_off;
		// Straps caught on the first clock after release
		if (!s_r.loaded) begin
			s_nxt.loaded = 1'b1;
			s_nxt.sel = indicator_select_strap;
			s_nxt.fun = indicator_function_strap;
			s_nxt.strap_hi = indicator_polarity_strap;
		end else if (cfg_write) begin
			s_nxt.sel = indicator_select_bits;
			s_nxt.fun = indicator_function_code;
		end
		active = act & ~{6{s_r.off}};
		push_pull = (s_r.fun == sli_pkg::FUN_RAW);
		for (i = 0; i < 6; i++) begin
			if (!s_r.sel[i]) begin
				// GPIO mode: released here, GPIO logic owns the pin
				s_nxt.pout[i] = 1'b0;
				s_nxt.poe_b[i] = 1'b1;
				s_nxt.gin[i] = 1'b1;
				s_nxt.gpu[i] = 1'b1;
			end else begin
				s_nxt.gin[i] = 1'b0;
				s_nxt.gpu[i] = 1'b0;
				if (push_pull) begin
					// Push-pull stays driven when off, low is inactive
					s_nxt.pout[i] = active[i];
					s_nxt.poe_b[i] = 1'b0;
				end else begin
					// Active drives the inverse strap level
					s_nxt.pout[i] = ~s_r.strap_hi[i];
					// Inactive or globally off is undriven
					s_nxt.poe_b[i] = ~active[i];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_r <= '{poe_b: 6'h3f, gin: 6'h3f, gpu: 6'h3f, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sif.event_hit = evt;

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign pin_out = s_r.pout;
	assign pin_oe_b = s_r.poe_b;
	assign gpio_input_enable = s_r.gin;
	assign gpio_pullup_enable = s_r.gpu;
	assign select_state = s_r.sel;
	assign function_state = s_r.fun;
endmodule

// file: hdl/sli_pkg.sv
/*
 * Constants and types for the switch port status indicator block.
 * Assumes a 50 MHz system clock; straps are stable around reset release.
 */
package sli_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int PIN_COUNT = 6;
	localparam int FUNC_W = 3;
	localparam int PORT_COUNT = 3;

	// ---------------------------------------------------------------
	// Function codes
	// ---------------------------------------------------------------
	localparam logic [2:0] FUN_SPD_DPX_LACT = 3'h0;
	localparam logic [2:0] FUN_10LA_DPX_100LA = 3'h1;
	localparam logic [2:0] FUN_SPD_LACT_RXTX = 3'h2;
	localparam logic [2:0] FUN_SPD_LINK_ACT = 3'h3;
	localparam logic [2:0] FUN_DPX_LINK_ACT = 3'h4;
	localparam logic [2:0] FUN_100L_10L_ACT = 3'h5;
	localparam logic [2:0] FUN_RESERVED = 3'h6;
	localparam logic [2:0] FUN_RAW = 3'h7;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam longint CLOCK_HZ = 50000000;
	localparam longint PULSE_MS = 80;
	localparam longint PULSE_CYCLES = CLOCK_HZ / 1000 * PULSE_MS;
	localparam int TIMER_W = 23;

	// ---------------------------------------------------------------
	// Per-pin stretch timer phases
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SLI_IDLE,
		SLI_PULSE,
		SLI_GAP
	} sli_phase_t;

	typedef struct packed {
		sli_phase_t phase;
		logic [TIMER_W-1:0] count;
	} sli_stretch_t;

endpackage

// file: hdl/sli_stretch_if.sv
/*
 * Bundle between the indicator top and its pulse stretchers.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface sli_stretch_if;
	logic [sli_pkg::PIN_COUNT-1:0] event_hit;
	logic [sli_pkg::PIN_COUNT-1:0] pulse_on;
	modport top (output event_hit, input pulse_on);
	modport stretch (input event_hit, output pulse_on);
endinterface

// file: hdl/sli_stretch.sv
/*
 * One 80 ms pulse stretcher per indicator pin, each followed by an 80 ms gap.
 * Assumes event_hit comes from logic on the same clock.
 */
`timescale 1ns/1ps
module sli_stretch #(
	parameter logic [sli_pkg::TIMER_W-1:0] PULSE_LEN =
		sli_pkg::TIMER_W'(sli_pkg::PULSE_CYCLES)
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_sync_b,
	// Events and stretched pulses
	sli_stretch_if.stretch sif
);
	// ---------------------------------------------------------------
	// Timers
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < sli_pkg::PIN_COUNT; gi++) begin : g_pin
			sli_pkg::sli_stretch_t st_r;
			sli_pkg::sli_stretch_t st_nxt;
			always_comb begin
				st_nxt = st_r;
				unique case (st_r.phase)
					sli_pkg::SLI_IDLE: begin
						// New event only after gap elapsed
						if (sif.event_hit[gi]) begin
							st_nxt.phase = sli_pkg::SLI_PULSE;
							st_nxt.count = PULSE_LEN - 1'b1;
						end
					end
					sli_pkg::SLI_PULSE: begin
						if (st_r.count == '0) begin
							st_nxt.phase = sli_pkg::SLI_GAP;
							st_nxt.count = PULSE_LEN - 1'b1;
						end else begin
							st_nxt.count = st_r.count - 1'b1;
						end
					end
					sli_pkg::SLI_GAP: begin
						// Events during the gap are dropped, not queued
						if (st_r.count == '0) begin
							st_nxt.phase = sli_pkg::SLI_IDLE;
						end else begin
							st_nxt.count = st_r.count - 1'b1;
						end
					end
					default: begin
						st_nxt.phase = sli_pkg::SLI_IDLE;
					end
				endcase
			end
			always_ff @(posedge clock or negedge rst_sync_b) begin
				if (!rst_sync_b) begin
					st_r <= '{phase: sli_pkg::SLI_IDLE, count: '0};
				end else begin
					st_r <= st_nxt;
				end
			end
			assign sif.pulse_on[gi] = (st_r.phase == sli_pkg::SLI_PULSE);
		end
	endgenerate
endmodule

// file: verification/sli_indicator_sva.sv
/* Port checker for the status indicator top.
   Assumes straps are held constant through the run. */
`timescale 1ns/1ps
module sli_indicator_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Inputs
	input wire logic [5:0] indicator_polarity_strap,
	input wire logic indicator_global_off,
	input wire logic [2:0] port_link,
	input wire logic [2:0] port_speed_100,
	input wire logic [2:0] port_full_duplex,
	input wire logic [2:0] port_rx_dv,
	// Outputs
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe_b,
	input wire logic [5:0] gpio_input_enable,
	input wire logic [5:0] gpio_pullup_enable,
	input wire logic [5:0] select_state,
	input wire logic [2:0] function_state
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// ----
	// Config held long enough for synced status to reach the pins
	// ----
	sequence s_cfg(logic [2:0] c);
		(function_state == c && select_state == 6'h3f && !indicator_global_off) [*4];
	endsequence
	property p_gpio_in; gpio_input_enable == ~$past(select_state); endproperty
	a_gpio_in: assert property (p_gpio_in) else $error("input buffer wrong");
	property p_gpio_pu; gpio_pullup_enable == ~$past(select_state); endproperty
	a_gpio_pu: assert property (p_gpio_pu) else $error("pull-up wrong");
	property p_unsel; (pin_oe_b | $past(select_state)) == 6'h3f; endproperty
	a_unsel: assert property (p_unsel) else $error("unselected pin driven");
	property p_pol; (function_state != sli_pkg::FUN_RAW) [*2] |->
		(~pin_oe_b & (pin_out ^ ~indicator_polarity_strap)) == 6'h00; endproperty
	a_pol: assert property (p_pol) else $error("active level wrong");
	property p_rsv; (function_state == sli_pkg::FUN_RESERVED) [*2] |-> pin_oe_b == 6'h3f;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code drives");
	property p_off; (function_state != sli_pkg::FUN_RAW && indicator_global_off) [*3]
		|-> pin_oe_b == 6'h3f; endproperty
	a_off: assert property (p_off) else $error("open drain driven when off");
	property p_pp; (function_state == sli_pkg::FUN_RAW && select_state == 6'h3f) [*2]
		|-> pin_oe_b == 6'h00; endproperty
	a_pp: assert property (p_pp) else $error("push-pull released");
	property p_raw; s_cfg(sli_pkg::FUN_RAW) |-> pin_out[0] == $past(port_rx_dv[1], 3);
	endproperty
	a_raw: assert property (p_raw) else $error("raw pin lags status");
	property p_link; s_cfg(sli_pkg::FUN_SPD_LINK_ACT) |->
		pin_oe_b[1] == !$past(port_link[1], 3); endproperty
	a_link: assert property (p_link) else $error("link pin wrong");
	property p_speed; s_cfg(sli_pkg::FUN_SPD_LINK_ACT) |->
		pin_oe_b[0] == !($past(port_link[1], 3) && $past(port_speed_100[1], 3)); endproperty
	a_speed: assert property (p_speed) else $error("speed pin wrong");
	property p_100l; s_cfg(sli_pkg::FUN_100L_10L_ACT) |->
		pin_oe_b[0] == !($past(port_link[1], 3) && $past(port_speed_100[1], 3)); endproperty
	a_100l: assert property (p_100l) else $error("100-link pin wrong");
	property p_fdx; s_cfg(sli_pkg::FUN_DPX_LINK_ACT) ##0 $past(port_full_duplex[1], 3)
		|-> pin_oe_b[0] == !$past(port_link[1], 3); endproperty
	a_fdx: assert property (p_fdx) else $error("duplex pin wrong");
endmodule
bind sli_indicator sli_indicator_sva u_sli_indicator_sva (.clock, .rst_b,
	.indicator_polarity_strap, .indicator_global_off, .port_link, .port_speed_100,
	.port_full_duplex, .port_rx_dv, .pin_out, .pin_oe_b, .gpio_input_enable,
	.gpio_pullup_enable, .select_state, .function_state);

// file: verification/sli_led_model.sv
/* Lamps on the shared pins.
   Assumes each pin has a resistor to its strap level. */
`timescale 1ns/1ps
module sli_led_model (
	// Pins
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe_b,
	input wire logic [5:0] strap_level,
	// Lamp state
	output logic [5:0] pad,
	output logic [5:0] lit
);
	// Released pin floats to the strap level, so it never shows the last drive
	assign pad = (pin_out & ~pin_oe_b) | (strap_level & pin_oe_b);
	assign lit = pad ^ strap_level;
endmodule

// file: verification/test_sli_indicator.sv
/* Self-checking bench for the status indicator.
   Assumes the lamp model; full 80 ms spans are too long to run. */
`timescale 1ns/1ps
module test_sli_indicator;
	// ----
	// Signals
	// ----
	localparam logic [5:0] SEL_STRAP = 6'h2d;
	localparam logic [2:0] FUN_STRAP = 3'h3;
	localparam logic [5:0] POL = 6'h15;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic cfg_write = 1'b0;
	logic glob_off = 1'b0;
	logic [5:0] sel_bits = 6'h00;
	logic [2:0] fun_code = 3'h0;
	logic [2:0] link = 3'h6, spd = 3'h2, fdx = 3'h2, col = 3'h0, txe = 3'h0, rxd = 3'h0;
	logic [5:0] pin_out, pin_oe_b, gpio_ie, gpio_pu, sel_st, pad, lit;
	logic [2:0] fun_st;
	int fails = 0;
	int samples_checked = 0;
	sli_indicator u_sli_indicator (.clock(clock), .rst_b(rst_b),
		.indicator_select_strap(SEL_STRAP), .indicator_function_strap(FUN_STRAP),
		.indicator_polarity_strap(POL), .cfg_write(cfg_write),
		.indicator_select_bits(sel_bits), .indicator_function_code(fun_code),
		.indicator_global_off(glob_off), .port_link(link), .port_speed_100(spd),
		.port_full_duplex(fdx), .port_collision(col), .port_tx_en(txe),
		.port_rx_dv(rxd), .port0_external(1'b0), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
		.gpio_input_enable(gpio_ie), .gpio_pullup_enable(gpio_pu),
		.select_state(sel_st), .function_state(fun_st));
	sli_led_model u_sli_led_model (.pin_out(pin_out), .pin_oe_b(pin_oe_b),
		.strap_level(POL), .pad(pad), .lit(lit));
	initial begin
		forever #10 clock = ~clock;
	end
	// ----
	// Helpers
	// ----
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic chk(input logic [5:0] got, input logic [5:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] s, input logic [2:0] c);
		cfg_write <= 1'b1;
		sel_bits <= s;
		fun_code <= c;
		tick(1);
		cfg_write <= 1'b0;
		tick(6);
	endtask
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		chk(sel_st, SEL_STRAP);
		chk({3'h0, fun_st}, {3'h0, FUN_STRAP});
		chk(gpio_ie, ~SEL_STRAP);
		chk(gpio_pu, ~SEL_STRAP);
	endtask
	// Port 1 at 100 full duplex, port 2 at 10 half duplex, no traffic
	task automatic t_codes;
		logic [5:0] exp [8];
		exp = '{6'h18, 6'h31, 6'h2c, 6'h2c, 6'h2c, 6'h2e, 6'h3f, 6'h00};
		for (int c = 0; c < 8; c++) begin
			wr(6'h3f, 3'(c));
			chk(pin_oe_b, exp[c]);
			if (c < 7) chk(pin_out, ~POL);
			if (c < 6) chk(lit, ~exp[c]);
		end
	endtask
	// One-cycle event, then the pin must flip and stay stretched
	task automatic t_pulse(input logic [2:0] code, input int pin, input logic [2:0] t,
		input logic [2:0] r, input logic [2:0] k, input logic want);
		int n;
		wr(6'h3f, code);
		txe <= t;
		rxd <= r;
		col <= k;
		tick(1);
		txe <= 3'h0;
		rxd <= 3'h0;
		col <= 3'h0;
		n = 0;
		while (pin_oe_b[pin] !== want && n < 10) begin
			tick(1);
			n++;
		end
		chk({5'h0, pin_oe_b[pin]}, {5'h0, want});
		tick(1000);
		chk({5'h0, pin_oe_b[pin]}, {5'h0, want});
	endtask
	task automatic t_raw;
		txe <= 3'h5;
		rxd <= 3'h2;
		wr(6'h3f, 3'h7);
		chk(pin_out, 6'h31);
		glob_off <= 1'b1;
		tick(4);
		chk(pin_out, 6'h00);
		chk(pin_oe_b, 6'h00);
		wr(6'h3f, 3'h0);
		chk(pin_oe_b, 6'h3f);
		glob_off <= 1'b0;
		txe <= 3'h0;
		rxd <= 3'h0;
		wr(6'h0a, 3'h0);
		chk(pin_oe_b & 6'h35, 6'h35);
		chk(gpio_ie, 6'h35);
		chk(gpio_pu, 6'h35);
	endtask
	// ----
	// Sequence and watchdog
	// ----
	initial begin
		tick(4);
		rst_b <= 1'b1;
		tick(8);
		t_reset();
		t_codes();
		t_pulse(3'h0, 5, 3'h4, 3'h0, 3'h0, 1'b1);
		t_pulse(3'h2, 2, 3'h0, 3'h1, 3'h0, 1'b0);
		t_pulse(3'h0, 4, 3'h0, 3'h0, 3'h4, 1'b0);
		t_raw();
		end_sim();
	end
	// Run needs about 3,100 cycles; allow six times that
	initial begin
		#400000;
		fails++;
		end_sim();
	end
endmodule
